// >>> shared/tcpf_pkg.sv
// Package: register map, field layout and source codes of the prescale front end
package tcpf_pkg;
  // Register map
  localparam logic [3:0] TCPF_CFG_ADDR = 4'h0;
  localparam logic [3:0] TCPF_STAT_ADDR = 4'h1;
  localparam logic [7:0] TCPF_CFG_RESET = 8'h00;
  // Field positions in the configuration register
  localparam int TCPF_SRC_LSB = 5;
  localparam int TCPF_SYNC_BIT = 4;
  localparam int TCPF_PSC_LSB = 0;
  // Source field codes
  typedef enum logic [2:0] {
    TCPF_SRC_PIN = 3'b000,
    TCPF_SRC_PIN_INV = 3'b001,
    TCPF_SRC_SYS4 = 3'b010,
    TCPF_SRC_HFOSC = 3'b011,
    TCPF_SRC_LFOSC = 3'b100,
    TCPF_SRC_SECONDARY_OSCILLATOR = 3'b101,
    TCPF_SRC_RSV6 = 3'b110,
    TCPF_SRC_RSV7 = 3'b111
  } tcpf_src_t;
  // Quarter-rate system clock: one enable every four mclk cycles
  localparam logic [1:0] TCPF_SYS_DIV_LAST = 2'h3;
endpackage

// >>> logic/tcpf_front_end.sv
// Clock source selection, synchronisation and prescaler of a general timer
`timescale 1ns/1ps
//
// Contract
// - Source 101 secondary osc, 100 low-freq osc, 011 high-freq osc, 010 sys/4.
// - Source 001 takes routed pin inverted, 000 takes it uninverted.
// - Ratio code 0000 passes source undivided, 0001 divides by two.
// - Each ratio increment doubles division: 0111 gives 128, 1000 gives 256.
// - Ratio 1111 divides by 32768, 1110 by 16384.
//
// Register at index 0 holds three fields:
//   bits 7:5 count source select
//   bit 4 input sync bypass
//   bits 3:0 prescale ratio select
// Index 1 is a read-only status word: bit 0 the sampled source
// level, bit 1 a synchronised count still waiting for its slot.
//
// All sources arrive as levels sampled on mclk; edges become count pulses.
// A source must stay high and low for at least one mclk each, so the
// fastest usable source runs at half of mclk; faster edges are lost.
// The prescaler is not cleared by a config write: the first count after
// a ratio change may come early, a trade for a smaller write path.
//
// Timing, in mclk cycles after the edge that samples a source edge:
//   bypass: count_tick is high in the following cycle
//   sync: count_tick follows the next sys/4 slot by one cycle
// A change of source masks edges for one cycle to avoid a false count.
// Reserved source codes leave the prescaler and count_tick quiet.
module tcpf_front_end (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Clock sources
  input wire logic count_pin,
  input wire logic secondary_oscillator,
  input wire logic low_freq_internal_osc,
  input wire logic high_freq_internal_osc,
  // Count output to the counter
  output logic count_tick
);
  import tcpf_pkg::*;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Tap mask of the ripple divider for each ratio code
  function automatic logic [14:0] ratio_mask(input logic [3:0] code);
    logic [14:0] mask;
    mask = 15'h0000;
    case (code)
      4'h0: mask = 15'h0000;
      4'h1: mask = 15'h0001;
      4'h2: mask = 15'h0003;
      4'h3: mask = 15'h0007;
      4'h4: mask = 15'h000F;
      4'h5: mask = 15'h001F;
      4'h6: mask = 15'h003F;
      4'h7: mask = 15'h007F;
      4'h8: mask = 15'h00FF;
      4'h9: mask = 15'h01FF;
      4'hA: mask = 15'h03FF;
      4'hB: mask = 15'h07FF;
      4'hC: mask = 15'h0FFF;
      4'hD: mask = 15'h1FFF;
      4'hE: mask = 15'h3FFF;
      4'hF: mask = 15'h7FFF;
      default: mask = 15'h7FFF;
    endcase
    return mask;
  endfunction

  // Tap of the ripple divider whose rising edge marks one division period
  function automatic logic ratio_reached(input logic [14:0] cnt,
                                         input logic [3:0] code);
    logic [14:0] mask;
    mask = ratio_mask(code);
    return (cnt & mask) == mask;
  endfunction

  // Read view of one register index; unmapped indices read as zero
  function automatic logic [7:0] read_view(input logic [3:0] addr,
                                           input logic [7:0] cfg,
                                           input logic [7:0] stat);
    logic [7:0] view;
    view = 8'h00;
    case (addr)
      TCPF_CFG_ADDR: view = cfg;
      TCPF_STAT_ADDR: view = stat;
      default: view = 8'h00;
    endcase
    return view;
  endfunction

  // Level of the chosen source; reserved codes give a quiet low level
  function automatic logic source_level(input logic [2:0] code,
                                        input logic pin,
                                        input logic so_lvl,
                                        input logic lf_lvl,
                                        input logic hf_lvl,
                                        input logic sys_lvl);
    logic lvl;
    lvl = 1'b0;
    case (tcpf_src_t'(code))
      TCPF_SRC_SECONDARY_OSCILLATOR: lvl = so_lvl;
      TCPF_SRC_LFOSC: lvl = lf_lvl;
      TCPF_SRC_HFOSC: lvl = hf_lvl;
      TCPF_SRC_SYS4: lvl = sys_lvl;
      TCPF_SRC_PIN_INV: lvl = ~pin;
      TCPF_SRC_PIN: lvl = pin;
      // Reserved codes select nothing, so a stray write cannot count
      default: lvl = 1'b0;
    endcase
    return lvl;
  endfunction

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  // The config register is written whole; the status word is read-only,
  // and reads of any other index return zero.
  logic [7:0] cfg_q, cfg_d;
  logic [7:0] rdata_q, rdata_d;
  logic [2:0] count_source_select;
  logic input_sync_bypass;
  logic [3:0] prescale_ratio_select;
  logic [7:0] status_w;
  logic sel_level_q;
  logic pending_q;

  assign count_source_select = cfg_q[TCPF_SRC_LSB +: 3];
  assign input_sync_bypass = cfg_q[TCPF_SYNC_BIT];
  assign prescale_ratio_select = cfg_q[TCPF_PSC_LSB +: 4];
  assign status_w = {6'h00, pending_q, sel_level_q};

  always_comb begin
    cfg_d = cfg_q;
    rdata_d = 8'h00;
    if (reg_wr && reg_addr == TCPF_CFG_ADDR) begin
      cfg_d = reg_wdata;
    end
    if (reg_rd) begin
      rdata_d = read_view(reg_addr, cfg_q, status_w);
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cfg_q <= TCPF_CFG_RESET;
      rdata_q <= 8'h00;
    end else begin
      cfg_q <= cfg_d;
      rdata_q <= rdata_d;
    end
  end
  assign reg_rdata = rdata_q;

  // ----------------------------------------------------------------
  // Quarter-rate system clock
  // ----------------------------------------------------------------
  // Free-running divider; its top bit is the sys/4 square wave and its
  // last count opens the slot for synchronised counts.
  logic [1:0] sys_div_q, sys_div_d;
  logic sys_en;

  assign sys_en = (sys_div_q == TCPF_SYS_DIV_LAST);

  always_comb begin
    sys_div_d = sys_div_q + 2'h1;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      sys_div_q <= 2'h0;
    end else begin
      sys_div_q <= sys_div_d;
    end
  end

  // ----------------------------------------------------------------
  // Source selection and edge detection
  // ----------------------------------------------------------------
  // A change of source would compare the new level against the old
  // source's sample; that cycle is masked so no false edge is counted.
  logic sel_level_d;
  logic [2:0] src_q, src_d;
  logic src_change;
  logic sel_edge;

  always_comb begin
    src_d = count_source_select;
    src_change = (src_q != count_source_select);
    sel_level_d = source_level(count_source_select, count_pin,
                               secondary_oscillator,
                               low_freq_internal_osc,
                               high_freq_internal_osc, sys_div_q[1]);
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      src_q <= TCPF_CFG_RESET[TCPF_SRC_LSB +: 3];
      sel_level_q <= 1'b0;
    end else begin
      src_q <= src_d;
      sel_level_q <= sel_level_d;
    end
  end
  assign sel_edge = sel_level_d & ~sel_level_q & ~src_change;

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  // Counts selected edges; the ratio code only picks the tap, so a
  // ratio change takes effect at once without a reload, at the cost
  // of one early first count.
  logic [14:0] psc_q, psc_d;
  logic psc_out;

  always_comb begin
    psc_d = psc_q;
    psc_out = 1'b0;
    if (sel_edge) begin
      // Power-of-two ratio from the tap mask
      if (ratio_reached(psc_q, prescale_ratio_select)) begin
        psc_d = 15'h0000;
        psc_out = 1'b1;
      end else begin
        psc_d = psc_q + 15'h0001;
      end
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      psc_q <= 15'h0000;
    end else begin
      psc_q <= psc_d;
    end
  end

  // ----------------------------------------------------------------
  // Synchronisation to the quarter-rate clock
  // ----------------------------------------------------------------
  // A pending count waits for the next sys/4 slot; a second count
  // arriving while one waits is merged, a limit of synchronised mode.
  // In bypass the tick follows the prescaler one cycle later and any
  // waiting count is dropped, so a mode switch never doubles a count.
  logic pending_d;
  logic tick_d, tick_q;

  // Whether a waiting or fresh count leaves in this slot
  function automatic logic slot_fire(input logic slot,
                                     input logic waiting,
                                     input logic fresh);
    return slot && (waiting || fresh);
  endfunction

  always_comb begin
    pending_d = pending_q;
    if (input_sync_bypass) begin
      pending_d = 1'b0;
    end else if (sys_en) begin
      pending_d = 1'b0;
    end else if (psc_out) begin
      pending_d = 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pending_q <= 1'b0;
    end else begin
      pending_q <= pending_d;
    end
  end

  // ----------------------------------------------------------------
  // Count output register
  // ----------------------------------------------------------------
  always_comb begin
    tick_d = 1'b0;
    if (input_sync_bypass) begin
      tick_d = psc_out;
    end else begin
      tick_d = slot_fire(sys_en, pending_q, psc_out);
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      tick_q <= 1'b0;
    end else begin
      tick_q <= tick_d;
    end
  end
  assign count_tick = tick_q;
endmodule

// >>> verification/tcpf_assertions.sv
// Checker of the prescale front end ports
`timescale 1ns/1ps
module tcpf_assertions (
  // Watched ports
  input wire logic mclk,
  input wire logic reset,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic count_pin,
  input wire logic count_tick
);
  logic [7:0] cfg_q;
  always_ff @(posedge mclk or posedge reset)
    if (reset) cfg_q <= 8'h00;
    else if (reg_wr && reg_addr == 4'h0) cfg_q <= reg_wdata;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  a_read_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside its slot");
  a_read_back: assert property ($past(reg_rd && reg_addr == 4'h0)
    |-> reg_rdata == cfg_q) else $error("config read back wrong");
  a_pin_plain: assert property (
    cfg_q == 8'h10 && cfg_q == $past(cfg_q, 3) && $rose(count_pin)
    |-> ##[1:3] count_tick) else $error("no tick on pin rise");
  a_pin_inv: assert property (
    cfg_q == 8'h30 && cfg_q == $past(cfg_q, 3) && $fell(count_pin)
    |-> ##[1:3] count_tick) else $error("no tick on pin fall");
  a_sys_rate: assert property (
    count_tick && cfg_q == 8'h50 && cfg_q == $past(cfg_q, 3)
    |-> ##4 (count_tick || cfg_q != 8'h50)) else $error("sys rate off");
  a_ratio_two: assert property (
    count_tick && cfg_q == 8'h71 && cfg_q == $past(cfg_q, 3)
    |-> ##4 (count_tick || cfg_q != 8'h71)) else $error("ratio 2 off");
  a_sync_gap: assert property (count_tick && !cfg_q[4]
    |=> (!count_tick || cfg_q[4]) [*3]) else $error("sync tick too soon");
  a_reserved_quiet: assert property (
    cfg_q[7:6] == 2'b11 && cfg_q == $past(cfg_q, 6) |-> !count_tick)
    else $error("tick from reserved source");
  c_pin: cover property (cfg_q == 8'h30 && count_tick);
  c_sync: cover property (!cfg_q[4] && count_tick);
  c_read: cover property (reg_rd ##1 reg_rdata != 8'h00);
endmodule

// >>> verification/tcpf_osc_model.sv
// Oscillator sources seen by the prescale front end
`timescale 1ns/1ps
module tcpf_osc_model (
  // Clock
  input wire logic mclk,
  // Source levels
  output logic hf,
  output logic lf,
  output logic so
);
  logic [3:0] ph_q = 4'h0;
  // Stepped from mclk so edge spacing is exact; rises every 2, 8, 16
  always @(posedge mclk) ph_q <= ph_q + 4'h1;
  assign hf = ph_q[0];
  assign lf = ph_q[2];
  assign so = ph_q[3];
endmodule

// >>> verification/tcpf_front_end_tb.sv
// Self-checking bench of the prescale front end
`timescale 1ns/1ps
module tcpf_front_end_tb;
  logic mclk = 0, reset = 1, reg_wr = 0, reg_rd = 0, count_pin = 0;
  logic rd_q = 0, count_tick, hf, lf, so;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, v;
  logic [7:0] exp_q[$];
  logic [7:0] cf[10] = '{8'hb0, 8'h90, 8'h70, 8'h50, 8'h71, 8'h77, 8'h78,
    8'h7e, 8'h60, 8'ha0};
  int ex[10] = '{16, 8, 2, 4, 4, 256, 512, 32768, 4, 16};
  int n_errors = 0, n_tests = 0;
  tcpf_osc_model tcpf_osc_model_i (.mclk, .hf, .lf, .so);
  tcpf_front_end tcpf_front_end_i (.mclk, .reset, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .count_pin, .secondary_oscillator(so),
    .low_freq_internal_osc(lf), .high_freq_internal_osc(hf), .count_tick);
  initial forever #2 mclk = ~mclk;
  always @(posedge mclk) count_pin <= 1'($urandom);
  task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      n_errors++;
      $display("mismatch %s expected %0h seen %0h", nm, e, s);
    end
  endtask
  always @(posedge mclk) begin
    rd_q <= reg_rd;
    if (rd_q) chk("rdata", reg_rdata, exp_q.pop_front());
  end
  // A read passes its expected value in d
  task automatic acc(logic w, logic [3:0] a, logic [7:0] d);
    @(posedge mclk);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    if (!w) exp_q.push_back(d);
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
  endtask
  // Prescaler is not cleared on a write: skip a tick, then time the next
  task automatic meas(logic [7:0] c, int e);
    int n;
    acc(1'b1, 4'h0, c);
    repeat (4) @(posedge mclk);
    repeat (2) begin
      n = 0;
      do begin
        @(posedge mclk);
        n++;
      end while (count_tick !== 1'b1 && n < 70000);
    end
    chk("interval", n, e);
  endtask
  task automatic complete_run;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #380000;
    n_errors++;
    complete_run;
  end
  initial begin
    void'($urandom(24));
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    acc(1'b0, 4'h0, 8'h00);
    acc(1'b0, 4'h5, 8'h00);
    v = {3'($urandom % 6), 5'($urandom)};
    acc(1'b1, 4'h0, v);
    acc(1'b1, 4'h3, ~v);
    acc(1'b0, 4'h0, v);
    acc(1'b1, 4'h0, 8'h10);
    repeat (300) @(posedge mclk);
    acc(1'b1, 4'h0, 8'h30);
    repeat (300) @(posedge mclk);
    foreach (cf[i]) meas(cf[i], ex[i]);
    acc(1'b1, 4'h0, 8'hd0);
    repeat (8) @(posedge mclk);
    v = 8'h00;
    repeat (200) begin
      @(posedge mclk);
      if (count_tick !== 1'b0) v++;
    end
    chk("quiet", v, 8'h00);
    acc(1'b0, 4'h1, 8'h00);
    repeat (4) @(posedge mclk);
    complete_run;
  end
endmodule
bind tcpf_front_end tcpf_assertions tcpf_assertions_i (.mclk, .reset,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .count_pin,
  .count_tick);
